// file: hw/cief_top.sv
// Core interrupt enable and flag registers with request generation.
// Also holds the peripheral enables and flags, and a sticky status with its mask.
// Assumes a classic Wishbone master on clk; pins are asynchronous and are synchronised here.
// Assumes the same-clock event inputs are pulses or levels from logic on clk.
//
// Contract
// - Every flag is set by its event regardless of its own enable and of the global enable.
// - With the global enable bit 7 clear no request reaches the core.
// - Peripheral requests also need the group enable bit 6 and their own enable.
// - The control register is readable and writable and holds timer0, port-B and pin bits.
// - The control register answers at four mirrored addresses, one per bank.
// - The timer0 enable bit masks or passes the timer0 overflow flag.
// - The pin flag is set by a pin event and cleared only by a software write of zero.
// - Peripheral enable bit 6 gates the converter completion interrupt.
// - Peripheral enable bit 3 gates the serial port interrupt.
// - Peripheral enable bit 1 gates the timer2 period match interrupt.
// - A peripheral flag register at 0Ch pairs each flag with the same enable bit.
//
// Decided for this implementation: register access over Wishbone.
`timescale 1ns/100ps
module cief_top (
    // Clock and reset.
    input  wire logic        clk,
    input  wire logic        nrst,
    // Wishbone slave.
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [12:0] wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    // Event sources.
    input  wire logic        timer0_overflow,
    input  wire logic        external_irq_pin,
    input  wire logic        ext_rising_edge,
    input  wire logic [3:0]  portb_upper_pins,
    input  wire logic [7:0]  periph_events,
    // Core request and system interrupt.
    output logic             core_irq_req,
    output logic             irq
);
    logic [7:0]  ctrl_r;
    logic [7:0]  pen_r;
    logic [7:0]  pflag_r;
    logic [3:0]  stat_r;
    logic [3:0]  mask_r;
    logic [1:0]  pin_sync_r;
    logic        pin_prev_r;
    logic [3:0]  pb_s1_r;
    logic [3:0]  pb_s2_r;
    logic [3:0]  pb_prev_r;
    logic        req_prev_r;
    logic [31:0] rdata_nxt;
    logic        req_nxt;
    logic        ext_evt;
    logic        pb_evt;
    logic        access;
    logic        wr;
    logic        rd;
    logic        hit_ctrl;
    logic        hit_pen;
    logic        hit_pflag;
    logic        hit_stat;
    logic        hit_mask;
    logic [8:0]  idx;
    logic        wr_ctrl;
    logic        wr_pen;
    logic        wr_pflag;
    logic        wr_mask;
    logic        rd_stat;
    logic [3:0]  stat_set;
    logic        t0_gate;
    logic        ext_gate;
    logic        pb_gate;
    logic        cnv_gate;
    logic        ser_gate;
    logic        ccp_gate;
    logic        t2m_gate;
    logic        t1o_gate;
    logic        periph_any;

    // Bus decode; the index is the word address.
    assign access    = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign wr        = access && wb_we_i && wb_sel_i[0];
    assign rd        = access && !wb_we_i;
    assign idx       = wb_adr_i[12:11] == 2'b00 ? wb_adr_i[10:2] : 9'h1FF;

    assign hit_ctrl  = (idx == cief_pkg::CTRL_IDX_B0) || (idx == cief_pkg::CTRL_IDX_B1)
                    || (idx == cief_pkg::CTRL_IDX_B2) || (idx == cief_pkg::CTRL_IDX_B3);
    assign hit_pen   = idx == cief_pkg::PEN_IDX;
    assign hit_pflag = idx == cief_pkg::PFLAG_IDX;
    assign hit_stat  = idx == cief_pkg::IRQ_STAT_IDX;
    assign hit_mask  = idx == cief_pkg::IRQ_MASK_IDX;

    // Per-register strobes.
    assign wr_ctrl   = wr && hit_ctrl;
    assign wr_pen    = wr && hit_pen;
    assign wr_pflag  = wr && hit_pflag;
    assign wr_mask   = wr && hit_mask;
    assign rd_stat   = rd && hit_stat;

    // Pin synchronisers, two stages before any logic.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            pin_sync_r <= 2'b00;
            pin_prev_r <= 1'b0;
        end else begin
            pin_sync_r <= {pin_sync_r[0], external_irq_pin};
            pin_prev_r <= pin_sync_r[1];
        end
    end

    // Port-B synchronisers and change history.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            pb_s1_r    <= 4'h0;
            pb_s2_r    <= 4'h0;
            pb_prev_r  <= 4'h0;
        end else begin
            pb_s1_r    <= portb_upper_pins;
            pb_s2_r    <= pb_s1_r;
            pb_prev_r  <= pb_s2_r;
        end
    end

    assign ext_evt = ext_rising_edge ? (pin_sync_r[1] && !pin_prev_r)
                                     : (!pin_sync_r[1] && pin_prev_r);
    // Port-B change
    assign pb_evt  = pb_s2_r != pb_prev_r;

    // Status events: request rise, timer0, port-B, pin.
    assign stat_set = {req_nxt && !req_prev_r, timer0_overflow, pb_evt, ext_evt};

    // Source gating; each flag is masked by its own enable.
    // timer0 gating
    assign t0_gate    = ctrl_r[cief_pkg::T0E_BIT] && ctrl_r[cief_pkg::T0F_BIT];
    assign ext_gate   = ctrl_r[cief_pkg::EXE_BIT] && ctrl_r[cief_pkg::EXF_BIT];
    assign pb_gate    = ctrl_r[cief_pkg::PBE_BIT] && ctrl_r[cief_pkg::PBF_BIT];
    assign cnv_gate   = pen_r[cief_pkg::CNV_BIT] && pflag_r[cief_pkg::CNV_BIT];
    assign ser_gate   = pen_r[cief_pkg::SER_BIT] && pflag_r[cief_pkg::SER_BIT];
    assign t2m_gate   = pen_r[cief_pkg::T2M_BIT] && pflag_r[cief_pkg::T2M_BIT];
    assign ccp_gate   = pen_r[cief_pkg::CCP_BIT] && pflag_r[cief_pkg::CCP_BIT];
    assign t1o_gate   = pen_r[cief_pkg::T1O_BIT] && pflag_r[cief_pkg::T1O_BIT];
    assign periph_any = cnv_gate || ser_gate || ccp_gate || t2m_gate || t1o_gate;

    // Control register; hardware set wins over software clear.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ctrl_r <= cief_pkg::CTRL_RST;
        end else begin
            if (wr_ctrl) begin
                ctrl_r <= wb_dat_i[7:0];
            end
            if (timer0_overflow) begin
                ctrl_r[cief_pkg::T0F_BIT] <= 1'b1;
            end
            if (ext_evt) begin
                ctrl_r[cief_pkg::EXF_BIT] <= 1'b1;
            end
            if (pb_evt) begin
                ctrl_r[cief_pkg::PBF_BIT] <= 1'b1;
            end
        end
    end

    // Peripheral enable register; reserved bits are held at zero.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            pen_r <= cief_pkg::PEN_RST;
        end else if (wr_pen) begin
            pen_r <= wb_dat_i[7:0] & cief_pkg::PEN_WMASK;
        end
    end

    generate
        for (genvar i = 0; i < 8; i++) begin : g_pflag
            always_ff @(posedge clk or negedge nrst) begin
                if (!nrst) begin
                    pflag_r[i] <= cief_pkg::PFLAG_RST[i];
                end else if (periph_events[i]) begin
                    pflag_r[i] <= 1'b1;
                end else if (wr_pflag) begin
                    pflag_r[i] <= wb_dat_i[i];
                end
            end
        end
    endgenerate

    // Request combination.
    always_comb begin
        req_nxt = 1'b0;
        if (t0_gate) begin
            req_nxt = 1'b1;
        end
        if (ext_gate || pb_gate) begin
            req_nxt = 1'b1;
        end
        if (ctrl_r[cief_pkg::PGE_BIT] && periph_any) begin
            req_nxt = 1'b1;
        end
        if (!ctrl_r[cief_pkg::GIE_BIT]) begin
            req_nxt = 1'b0;
        end
    end

    // Registered request to the core.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            core_irq_req <= 1'b0;
        end else begin
            core_irq_req <= req_nxt;
        end
    end

    // Previous request, for the rise event in the status register.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            req_prev_r   <= 1'b0;
        end else begin
            req_prev_r   <= req_nxt;
        end
    end

    // Sticky interrupt status, cleared by a read; a new event wins.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            stat_r <= cief_pkg::STAT_RST;
        end else begin
            stat_r <= (rd_stat ? 4'h0 : stat_r) | stat_set;
        end
    end

    // Interrupt mask register.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            mask_r <= cief_pkg::MASK_RST;
        end else if (wr_mask) begin
            mask_r <= wb_dat_i[3:0];
        end
    end

    // Level interrupt from unmasked status bits.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            irq <= 1'b0;
        end else begin
            irq <= |(stat_r & mask_r);
        end
    end

    // Read data; unmapped addresses read zero and still acknowledge.
    always_comb begin
        rdata_nxt = 32'h0000_0000;
        if (hit_ctrl) begin
            rdata_nxt[7:0] = ctrl_r;
        end else if (hit_pen) begin
            rdata_nxt[7:0] = pen_r;
        end else if (hit_pflag) begin
            rdata_nxt[7:0] = pflag_r;
        end else if (hit_stat) begin
            rdata_nxt[3:0] = stat_r;
        end else if (hit_mask) begin
            rdata_nxt[3:0] = mask_r;
        end
    end

    // Acknowledge, one cycle per request.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= access;
        end
    end

    // Read data, valid only with the acknowledge.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_dat_o <= rd ? rdata_nxt : 32'h0000_0000;
        end
    end
endmodule

// file: pkg/cief_pkg.sv
// Package for the core interrupt enable and flag block.
// Assumes an 8-bit register space reached over classic Wishbone with 32-bit data.
package cief_pkg;
    // Register indices as printed; byte address is four times the index.
    localparam logic [8:0] CTRL_IDX_B0   = 9'h00B;
    localparam logic [8:0] CTRL_IDX_B1   = 9'h08B;
    localparam logic [8:0] CTRL_IDX_B2   = 9'h10B;
    localparam logic [8:0] CTRL_IDX_B3   = 9'h18B;
    localparam logic [8:0] PFLAG_IDX     = 9'h00C;
    localparam logic [8:0] PEN_IDX       = 9'h08C;
    localparam logic [8:0] IRQ_STAT_IDX  = 9'h0F0;
    localparam logic [8:0] IRQ_MASK_IDX  = 9'h0F1;
    localparam int         ADR_W         = 11;
    // Control register fields.
    localparam int GIE_BIT   = 7;
    localparam int PGE_BIT   = 6;
    localparam int T0E_BIT   = 5;
    localparam int EXE_BIT   = 4;
    localparam int PBE_BIT   = 3;
    localparam int T0F_BIT   = 2;
    localparam int EXF_BIT   = 1;
    localparam int PBF_BIT   = 0;
    // Peripheral enable layout and writable bits.
    localparam int CNV_BIT   = 6;
    localparam int SER_BIT   = 3;
    localparam int CCP_BIT   = 2;
    localparam int T2M_BIT   = 1;
    localparam int T1O_BIT   = 0;
    localparam logic [7:0] PEN_WMASK  = 8'h4F;
    // Reset values.
    localparam logic [7:0] CTRL_RST   = 8'h00;
    localparam logic [7:0] PEN_RST    = 8'h00;
    localparam logic [7:0] PFLAG_RST  = 8'h00;
    localparam logic [3:0] STAT_RST   = 4'h0;
    localparam logic [3:0] MASK_RST   = 4'h0;
    // Interrupt status layout: ext pin, port-B change, timer0, request rise.
    localparam int ST_EXT    = 0;
    localparam int ST_PB     = 1;
    localparam int ST_T0     = 2;
    localparam int ST_REQ    = 3;
endpackage

// file: tb/cief_asserts.sv
// Checker of bus timing, read values and request gating at the block's ports.
// Assumes a one-cycle acknowledge and a request registered like the read data.
`timescale 1ns/100ps
module cief_asserts (
    // Clock and reset.
    input wire logic        clk,
    input wire logic        nrst,
    // Bus.
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [12:0] wb_adr_i,
    input wire logic [3:0]  wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    // Events and requests.
    input wire logic        timer0_overflow,
    input wire logic        external_irq_pin,
    input wire logic        ext_rising_edge,
    input wire logic [3:0]  portb_upper_pins,
    input wire logic [7:0]  periph_events,
    input wire logic        core_irq_req,
    input wire logic        irq
);
    logic       rd_ctl;
    logic [7:0] v;
    assign rd_ctl = wb_cyc_i & wb_stb_i & ~wb_ack_o & ~wb_we_i & (wb_adr_i[12:11] == 2'h0)
                    & (wb_adr_i[8:2] == 7'h0B);
    assign v = wb_dat_o[7:0];
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    chk_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    chk_ack_latency: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("ack not one cycle after request");
    chk_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0000_0000)
        else $error("read data outside ack");
    chk_pen_reserved: assert property (wb_ack_o && $past(!wb_we_i && wb_adr_i == 13'h0230)
        |-> (wb_dat_o & 32'hFFFF_FFB0) == 32'h0000_0000)
        else $error("reserved enable bits read as one");
    chk_flag_sets: assert property (timer0_overflow ##1 rd_ctl |=> v[2])
        else $error("timer0 flag not set by event");
    chk_gie_off: assert property (wb_ack_o && $past(rd_ctl) && !v[7] |-> !core_irq_req)
        else $error("request with global enable clear");
    chk_group_off: assert property (wb_ack_o && $past(rd_ctl) && !v[6]
        && (v[5:3] & v[2:0]) == 3'h0 |-> !core_irq_req)
        else $error("peripheral request without group enable");
    chk_core_pair: assert property (wb_ack_o && $past(rd_ctl) && v[7]
        && (v[5:3] & v[2:0]) != 3'h0 |-> core_irq_req)
        else $error("enabled core flag gave no request");
endmodule
bind cief_top cief_asserts cief_asserts_i (.clk(clk), .nrst(nrst), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .irq(irq),
    .timer0_overflow(timer0_overflow), .external_irq_pin(external_irq_pin),
    .ext_rising_edge(ext_rising_edge), .portb_upper_pins(portb_upper_pins),
    .periph_events(periph_events), .core_irq_req(core_irq_req));

// file: tb/cief_src.sv
// Model of the event sources beside the interrupt block.
// Assumes events are one-cycle pulses and pins move only when told.
`timescale 1ns/100ps
module cief_src (
    // Clock.
    input wire logic  clk,
    // Events toward the block.
    output logic       timer0_overflow,
    output logic       external_irq_pin,
    output logic [3:0] portb_upper_pins,
    output logic [7:0] periph_events
);
    initial begin
        {timer0_overflow, external_irq_pin, portb_upper_pins, periph_events} = '0;
    end
    // Each event lasts one cycle.
    always @(posedge clk) begin
        if (timer0_overflow) timer0_overflow <= 1'b0;
        if (|periph_events) periph_events <= 8'h00;
    end
    task pulse_t0();
        timer0_overflow <= 1'b1;
    endtask
    task pulse_pe(input int b);
        periph_events <= 8'h01 << b;
    endtask
    task set_pins(input logic p, input logic [3:0] b);
        {external_irq_pin, portb_upper_pins} <= {p, b};
    endtask
endmodule

// file: tb/cief_top_tb.sv
// Self-checking bench of the interrupt enable and flag block.
// Assumes the source model drives every event input.
`timescale 1ns/100ps
`define CK(g, e) begin samples_checked++; if ((g) !== (e)) begin mismatches++; \
    $display("mismatch at %0t: got %h exp %h", $time, g, e); end end
module cief_top_tb;
    logic        clk, nrst, cyc, stb, we, ack, req, irq, t0, pin, esel;
    logic [12:0] adr;
    logic [12:0] ctl [4];
    logic [31:0] wdat, rdat;
    logic [3:0]  pb;
    logic [7:0]  pe, r;
    int          mismatches, samples_checked;
    cief_top cief_top_i (.clk(clk), .nrst(nrst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(4'h1), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .timer0_overflow(t0), .external_irq_pin(pin), .ext_rising_edge(esel),
        .portb_upper_pins(pb), .periph_events(pe), .core_irq_req(req), .irq(irq));
    cief_src cief_src_i (.clk(clk), .timer0_overflow(t0), .external_irq_pin(pin),
        .portb_upper_pins(pb), .periph_events(pe));
    function automatic logic [12:0] ba(input logic [8:0] i);
        return {2'b00, i, 2'b00};
    endfunction
    task final_report();
        $display("checks %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task bus(input logic w, input logic [12:0] a, input logic [7:0] d);
        int n;
        @(posedge clk);
        {cyc, stb, we, adr, wdat} <= {2'b11, w, a, 24'h00_0000, d};
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 16);
        r = rdat[7:0];
        {cyc, stb} <= 2'b00;
        if (n >= 16) begin
            mismatches++;
            final_report();
        end
    endtask
    task req_is(input logic e);
        repeat (2) @(posedge clk);
        `CK(req, e)
    endtask
    task t_regs();
        bus(0, ctl[0], 8'h00);
        `CK(r, cief_pkg::CTRL_RST)
        bus(1, ba(cief_pkg::PEN_IDX), 8'hFF);
        bus(0, ba(cief_pkg::PEN_IDX), 8'h00);
        `CK(r, cief_pkg::PEN_WMASK)
        for (int i = 0; i < 4; i++) begin
            bus(1, ctl[i], 8'h08 << i);
            bus(0, ctl[(i + 1) % 4], 8'h00);
            `CK(r, 8'h08 << i)
        end
        bus(0, 13'h1000, 8'h00);
        `CK(r, 8'h00)
        bus(1, ctl[0], 8'h00);
        $display("registers done");
    endtask
    task t_core();
        cief_src_i.pulse_t0();
        bus(0, ctl[3], 8'h00);
        `CK(r[cief_pkg::T0F_BIT], 1'b1)
        bus(1, ctl[1], 8'hA4);
        req_is(1'b1);
        bus(0, ctl[2], 8'h00);
        `CK(r, 8'hA4)
        bus(1, ctl[1], 8'h84);
        req_is(1'b0);
        bus(1, ctl[1], 8'h24);
        req_is(1'b0);
        $display("core done");
    endtask
    task t_pin();
        cief_src_i.set_pins(1'b1, 4'h0);
        repeat (6) @(posedge clk);
        cief_src_i.set_pins(1'b0, 4'h8);
        repeat (6) @(posedge clk);
        bus(0, ctl[2], 8'h00);
        `CK(r[cief_pkg::EXF_BIT], 1'b1)
        `CK(r[cief_pkg::PBF_BIT], 1'b1)
        bus(1, ctl[2], 8'h89);
        req_is(1'b1);
        bus(1, ctl[2], 8'h00);
        bus(0, ctl[2], 8'h00);
        `CK(r, 8'h00)
        esel <= 1'b0;
        cief_src_i.set_pins(1'b1, 4'h8);
        repeat (6) @(posedge clk);
        bus(0, ctl[1], 8'h00);
        `CK(r, 8'h00)
        cief_src_i.set_pins(1'b0, 4'h8);
        repeat (6) @(posedge clk);
        bus(0, ctl[3], 8'h00);
        `CK(r, 8'h02)
        bus(1, ctl[0], 8'h00);
        esel <= 1'b1;
        $display("pins done");
    endtask
    task t_periph();
        int b [3];
        b = '{6, 3, 1};
        foreach (b[i]) begin
            bus(1, ba(cief_pkg::PFLAG_IDX), 8'h00);
            bus(1, ba(cief_pkg::PEN_IDX), 8'h01 << b[i]);
            cief_src_i.pulse_pe(b[i]);
            bus(0, ba(cief_pkg::PFLAG_IDX), 8'h00);
            `CK(r, 8'h01 << b[i])
            bus(1, ctl[0], 8'hC0);
            req_is(1'b1);
            bus(1, ctl[0], 8'h80);
            req_is(1'b0);
            bus(1, ba(cief_pkg::PEN_IDX), 8'h00);
            bus(1, ctl[0], 8'hC0);
            req_is(1'b0);
        end
        $display("peripherals done");
    endtask
    task t_irq();
        bus(0, ba(cief_pkg::IRQ_STAT_IDX), 8'h00);
        cief_src_i.pulse_t0();
        repeat (4) @(posedge clk);
        `CK(irq, 1'b0)
        bus(0, ba(cief_pkg::IRQ_STAT_IDX), 8'h00);
        `CK(r[cief_pkg::ST_T0], 1'b1)
        bus(1, ba(cief_pkg::IRQ_MASK_IDX), 8'h04);
        cief_src_i.pulse_t0();
        repeat (4) @(posedge clk);
        `CK(irq, 1'b1)
        bus(0, ba(cief_pkg::IRQ_STAT_IDX), 8'h00);
        repeat (3) @(posedge clk);
        `CK(irq, 1'b0)
        $display("interrupt done");
    endtask
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    initial begin
        nrst = 1'b0;
        {cyc, stb, we, adr, wdat} = '0;
        esel = 1'b1;
        mismatches = 0;
        samples_checked = 0;
        ctl = '{ba(cief_pkg::CTRL_IDX_B0), ba(cief_pkg::CTRL_IDX_B1),
                ba(cief_pkg::CTRL_IDX_B2), ba(cief_pkg::CTRL_IDX_B3)};
        repeat (6) @(posedge clk);
        nrst <= 1'b1;
        t_regs();
        t_core();
        t_pin();
        t_periph();
        t_irq();
        final_report();
    end
endmodule
